// file: smra_pkg.sv
// Contract
// R01: Region 0x00000000-0x0001FFFF maps to ROM, OTP or RAM per remap select.
// R02: Addresses 0x07F00000-0x07F1FFFF select the boot and link protocol ROM.
// R03: Addresses 0x07F40000-0x07F400FF select the OTP control registers.
// R04: Addresses 0x07F80000-0x07F8FFFF select the OTP cell array.
// R05: RAM spans 0x07FC0000-0x07FD7FFF; bank one then bank two at 0x07FC8000.
// R06: Bank three at 0x07FCC000, bank four 0x07FD0000-0x07FD7FFF.
// R07: Addresses 0x40080000-0x400803FF select the patch registers.
// R08: Peripheral slots of 256 bytes: power/clock, wake-up timer, quadrature decoder.
// R09: Consecutive 256-byte slots 0x50001000-0x500016FF for UARTs through analog miscellaneous.
// R10: Consecutive 256-byte slots 0x50003000-0x500036FF for ports through DMA.
// R11: Two fixed-priority arbiters serve masters in parallel on different cells.
// R12: Arbitrate CPU/DMA, OTP copier and link core; link core highest by default.
// R13: Contested arbiter is time-shared so no master monopolises it.
// R14: Retainable cells of 16 kB and 32 kB; retention configuration preserved.
// R15: Cells form one continuous space; only the needed banks are powered.
// R16: CPU/DMA port is clocked no faster than 16 MHz; here it is clocked by clk_sys at SYS_CLK_HZ, 20 MHz.
// R17: Link core port runs at 16 MHz, accessing its exchange memory directly; here it runs on clk_sys at 20 MHz.
// R18: OTP port writes directly into RAM while copying after power-up.
// R19: OTP first while mirroring; then link first, CPU one in three cycles.
// R20: With no request the arbiter selects its idle state.
// R21: Reserved addresses select nothing and leave memory unchanged.
package smra_pkg;
  localparam logic [31:0] BOOT_HI = 32'h0001ffff;
  localparam logic [31:0] ROM_LO = 32'h07f00000;
  localparam logic [31:0] ROM_HI = 32'h07f1ffff;
  localparam logic [31:0] OTPREG_LO = 32'h07f40000;
  localparam logic [31:0] OTPREG_HI = 32'h07f400ff;
  localparam logic [31:0] OTPCELL_LO = 32'h07f80000;
  localparam logic [31:0] OTPCELL_HI = 32'h07f8ffff;
  localparam logic [31:0] OTPCELL_SIZE = 32'h00010000;
  localparam logic [31:0] RAM_LO = 32'h07fc0000;
  localparam logic [31:0] RAM_HI = 32'h07fd7fff;
  localparam logic [31:0] LINKREG_LO = 32'h40000000;
  localparam logic [31:0] LINKREG_HI = 32'h4001ffff;
  localparam logic [31:0] PATCH_LO = 32'h40080000;
  localparam logic [31:0] PATCH_HI = 32'h400803ff;
  localparam logic [31:0] APB_AON_LO = 32'h50000000;
  localparam logic [31:0] APB_AON_HI = 32'h500002ff;
  localparam logic [31:0] APB_PER_LO = 32'h50001000;
  localparam logic [31:0] APB_PER_HI = 32'h500016ff;
  localparam logic [31:0] RADIO_LO = 32'h50002000;
  localparam logic [31:0] RADIO_HI = 32'h50002fff;
  localparam logic [31:0] APB_SYS_LO = 32'h50003000;
  localparam logic [31:0] APB_SYS_HI = 32'h500036ff;
  localparam logic [31:0] PRIV_LO = 32'he0000000;
  localparam logic [31:0] PRIV_HI = 32'he00fffff;
  localparam int N_MST = 3;
  localparam int N_BANK = 4;
  localparam int WORD_W = 13;
  localparam int M_OTP = 0;
  localparam int M_LINK = 1;
  localparam int M_CPU = 2;
  localparam logic [31:0] BANK_LO [N_BANK] = '{32'h07fc0000, 32'h07fc8000, 32'h07fcc000,
                                               32'h07fd0000};
  localparam logic [31:0] BANK_HI [N_BANK] = '{32'h07fc7fff, 32'h07fcbfff, 32'h07fcffff,
                                               32'h07fd7fff};
  localparam int BANK_KB [N_BANK] = '{32, 16, 16, 32};
  localparam logic [1:0] REMAP_ROM = 2'h0;
  localparam logic [1:0] REMAP_OTP = 2'h1;
  localparam logic [1:0] REMAP_RAM = 2'h2;
  localparam logic [1:0] LINK_RUN_MAX = 2'h2;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int PORT_MAX_HZ = 16000000;
  localparam int LINK_PORT_HZ = 16000000;

  typedef enum logic [3:0] {
    REG_NONE, REG_ROM, REG_OTP_CTRL, REG_OTP_CELL, REG_RAM, REG_LINK_CTRL, REG_PATCH,
    REG_APB, REG_RADIO, REG_PRIVATE
  } smra_region_type;

  typedef enum logic [1:0] {ARB_IDLE, ARB_OTP, ARB_LINK, ARB_CPU} smra_arb_state_type;

  typedef struct packed {
    logic hit;
    logic [1:0] bank;
    logic [WORD_W-1:0] word;
  } smra_loc_type;

  // Unpowered banks count as absent; addresses in them miss even where a live bank lies above
  function automatic smra_loc_type ram_map(input logic [31:0] addr,
                                           input logic [N_BANK-1:0] pwr);
    smra_loc_type loc;
    logic [31:0] off;
    loc = '0;
    off = '0;
    for (int b = 0; b < N_BANK; b++) begin
      if (addr >= BANK_LO[b] && addr <= BANK_HI[b] && pwr[b]) begin
        off = addr - BANK_LO[b];
        loc.hit = 1'b1;
        loc.bank = 2'(b);
        loc.word = off[WORD_W+1:2];
      end
    end
    return loc;
  endfunction : ram_map
endpackage : smra_pkg

// file: smra_arb_if.sv
`timescale 1ns/1ns
interface smra_arb_if;
  logic [2:0] req;
  logic [2:0] gnt;
  logic mirror;
  modport ctl (output req, output mirror, input gnt);
  modport arb (input req, input mirror, output gnt);
endinterface : smra_arb_if

// file: smra_arbiter.sv
`timescale 1ns/1ns
module smra_arbiter (
  input wire logic clk_sys,
  input wire logic arst_n,
  smra_arb_if.arb arb_io
);
  import smra_pkg::*;

  smra_arb_state_type state_d;
  smra_arb_state_type state_q;
  logic [1:0] run_q;
  logic cpu_turn;

  // ****************************************
  // Priority selection
  // ****************************************
  assign cpu_turn = arb_io.req[M_CPU] && run_q == LINK_RUN_MAX; // [R13]

  always_comb begin
    if (arb_io.req[M_OTP] && arb_io.mirror) begin
      state_d = ARB_OTP; // [R19] [R18]
    end else if (arb_io.req[M_LINK] && !cpu_turn) begin
      state_d = ARB_LINK; // [R12] [R19]
    end else if (arb_io.req[M_CPU]) begin
      state_d = ARB_CPU; // [R19]
    end else if (arb_io.req[M_OTP]) begin
      state_d = ARB_OTP;
    end else begin
      state_d = ARB_IDLE; // [R20]
    end
  end

  assign arb_io.gnt = {state_d == ARB_CPU, state_d == ARB_LINK, state_d == ARB_OTP}; // [R11]

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ARB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts link grants while the CPU waits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 2'h0;
    end else if (state_d == ARB_LINK && arb_io.req[M_CPU]) begin
      run_q <= run_q + 2'h1; // [R13]
    end else if (state_d == ARB_CPU || !arb_io.req[M_CPU]) begin
      run_q <= 2'h0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_link_streak;
    arb_io.req[M_LINK] && arb_io.req[M_CPU] && !arb_io.mirror && state_d == ARB_LINK;
  endsequence

  AST_IDLE_NO_REQ: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R20]
    arb_io.req == 3'h0 |=> state_q == ARB_IDLE)
    else $error("arbiter not idle without requests");
  AST_OTP_MIRROR_FIRST: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R19]
    arb_io.mirror && arb_io.req[M_OTP] |-> arb_io.gnt == 3'b001)
    else $error("otp not first while mirroring");
  AST_CPU_ONE_IN_THREE: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R13]
    s_link_streak ##1 s_link_streak |=> !(arb_io.req[M_CPU] && !arb_io.mirror)
      || arb_io.gnt[M_CPU])
    else $error("cpu starved by link core");
  AST_ONE_GRANT: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R11]
    $onehot0(arb_io.gnt))
    else $error("more than one grant");
endmodule : smra_arbiter

// file: smra_system_map.sv
`timescale 1ns/1ns
module smra_system_map (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [1:0] boot_region_remap_select,
  input wire logic [3:0] ram_banks_used,
  input wire logic [3:0] ram_retain_cfg,
  input wire logic otp_mirror_active,
  input wire logic [2:0] mst_req,
  input wire logic [2:0] mst_we,
  input wire logic [2:0][31:0] mst_addr,
  input wire logic [2:0][31:0] mst_wdata,
  output logic [2:0] mst_ack_q,
  output logic [2:0] mst_err_q,
  output logic [2:0] mst_rvalid_q,
  output logic [2:0][31:0] mst_rdata_q,
  output smra_pkg::smra_region_type cpu_region_q,
  output logic [31:0] cpu_slave_addr_q,
  output logic [7:0] cpu_slot_q,
  output logic [3:0] bank_en_q,
  output logic [3:0] bank_we_q,
  output logic [3:0][smra_pkg::WORD_W-1:0] bank_addr_q,
  output logic [3:0][31:0] bank_wdata_q,
  input wire logic [3:0][31:0] bank_rdata,
  output logic [3:0] bank_pwr_en_q,
  output logic [3:0] bank_retain_q
);
  import smra_pkg::*;

  smra_region_type cpu_region_d;
  logic [31:0] cpu_addr;
  logic [31:0] cpu_map_addr;
  logic [7:0] cpu_slot_d;
  logic [2:0][31:0] eff_addr;
  smra_loc_type loc [N_MST];
  logic [2:0] ram_req;
  logic [2:0] err_hit;
  logic [2:0] granted;
  logic [1:0][2:0] gnt_arb;
  logic [2:0] rd1_q;
  logic [2:0] rd2_q;
  logic [2:0][1:0] bank1_q;
  logic [2:0][1:0] bank2_q;
  logic cpu_ram;

  // ****************************************
  // CPU address decode
  // ****************************************
  assign cpu_addr = mst_addr[M_CPU];

  always_comb begin
    cpu_region_d = REG_NONE;
    cpu_map_addr = cpu_addr;
    cpu_slot_d = cpu_addr[15:8];
    if (cpu_addr <= BOOT_HI) begin
      unique case (boot_region_remap_select)
        REMAP_ROM: begin
          cpu_region_d = REG_ROM; // [R01]
          cpu_map_addr = ROM_LO + cpu_addr;
        end
        REMAP_OTP: begin
          cpu_map_addr = OTPCELL_LO + cpu_addr;
          // OTP is smaller than the boot window; the tail stays unmapped
          cpu_region_d = cpu_addr < OTPCELL_SIZE ? REG_OTP_CELL : REG_NONE; // [R01] [R21]
        end
        REMAP_RAM: begin
          cpu_map_addr = RAM_LO + cpu_addr;
          cpu_region_d = REG_RAM; // [R01]
        end
        default: begin
          cpu_region_d = REG_NONE; // [R21]
        end
      endcase
    end else if (cpu_addr >= ROM_LO && cpu_addr <= ROM_HI) begin
      cpu_region_d = REG_ROM; // [R02]
    end else if (cpu_addr >= OTPREG_LO && cpu_addr <= OTPREG_HI) begin
      cpu_region_d = REG_OTP_CTRL; // [R03]
    end else if (cpu_addr >= OTPCELL_LO && cpu_addr <= OTPCELL_HI) begin
      cpu_region_d = REG_OTP_CELL; // [R04]
    end else if (cpu_addr >= RAM_LO && cpu_addr <= RAM_HI) begin
      cpu_region_d = REG_RAM; // [R05] [R06]
    end else if (cpu_addr >= LINKREG_LO && cpu_addr <= LINKREG_HI) begin
      cpu_region_d = REG_LINK_CTRL;
    end else if (cpu_addr >= PATCH_LO && cpu_addr <= PATCH_HI) begin
      cpu_region_d = REG_PATCH; // [R07]
    end else if (cpu_addr >= APB_AON_LO && cpu_addr <= APB_AON_HI) begin
      cpu_region_d = REG_APB; // [R08]
    end else if (cpu_addr >= APB_PER_LO && cpu_addr <= APB_PER_HI) begin
      cpu_region_d = REG_APB; // [R09]
    end else if (cpu_addr >= RADIO_LO && cpu_addr <= RADIO_HI) begin
      cpu_region_d = REG_RADIO;
    end else if (cpu_addr >= APB_SYS_LO && cpu_addr <= APB_SYS_HI) begin
      cpu_region_d = REG_APB; // [R10]
    end else if (cpu_addr >= PRIV_LO && cpu_addr <= PRIV_HI) begin
      cpu_region_d = REG_PRIVATE;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpu_region_q <= REG_NONE;
      cpu_slot_q <= 8'h00;
      cpu_slave_addr_q <= 32'h00000000;
    end else begin
      cpu_region_q <= cpu_region_d;
      cpu_slot_q <= cpu_slot_d; // [R08] [R09] [R10]
      cpu_slave_addr_q <= cpu_map_addr;
    end
  end

  // ****************************************
  // Bank power and retention
  // ****************************************
  generate
    for (genvar b = 0; b < N_BANK; b++) begin : g_pwr
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          bank_pwr_en_q[b] <= 1'b1;
          bank_retain_q[b] <= 1'b0;
        end else begin
          // Retained banks stay powered even when not counted as used
          bank_pwr_en_q[b] <= ram_banks_used[b] | ram_retain_cfg[b]; // [R15] [R14]
          bank_retain_q[b] <= ram_retain_cfg[b]; // [R14]
        end
      end
    end
  endgenerate

  // ****************************************
  // Request steering
  // ****************************************
  assign cpu_ram = cpu_region_d == REG_RAM;
  assign eff_addr[M_OTP] = mst_addr[M_OTP];
  assign eff_addr[M_LINK] = mst_addr[M_LINK];
  assign eff_addr[M_CPU] = cpu_map_addr;

  generate
    for (genvar m = 0; m < N_MST; m++) begin : g_mst
      assign loc[m] = ram_map(eff_addr[m], bank_pwr_en_q); // [R15]
      if (m == M_CPU) begin : g_cpu
        assign ram_req[m] = mst_req[m] && !mst_ack_q[m] && loc[m].hit && cpu_ram;
        // Other regions are answered by their own slaves
        assign err_hit[m] = mst_req[m] && !mst_ack_q[m] && !loc[m].hit
                            && (cpu_region_d == REG_NONE || cpu_ram); // [R21]
      end else begin : g_dir
        assign ram_req[m] = mst_req[m] && !mst_ack_q[m] && loc[m].hit; // [R17] [R18]
        assign err_hit[m] = mst_req[m] && !mst_ack_q[m] && !loc[m].hit; // [R21]
      end
      assign granted[m] = gnt_arb[0][m] | gnt_arb[1][m];
    end
  endgenerate

  // Lower pair and upper pair of banks each have an arbiter
  generate
    for (genvar k = 0; k < 2; k++) begin : g_arb
      smra_arb_if bus ();
      for (genvar m = 0; m < N_MST; m++) begin : g_req
        assign bus.req[m] = ram_req[m] && loc[m].bank[1] == 1'(k); // [R11]
      end
      assign bus.mirror = otp_mirror_active;
      assign gnt_arb[k] = bus.gnt;
      smra_arbiter u_arb (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .arb_io(bus.arb)
      );
    end
  endgenerate

  // ****************************************
  // Bank command ports
  // ****************************************
  generate
    for (genvar b = 0; b < N_BANK; b++) begin : g_bank
      logic sel_v;
      logic [1:0] sel_m;
      always_comb begin
        sel_v = 1'b0;
        sel_m = 2'h0;
        for (int m = 0; m < N_MST; m++) begin
          if (gnt_arb[b / 2][m] && loc[m].bank == 2'(b)) begin
            sel_v = 1'b1;
            sel_m = 2'(m);
          end
        end
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          bank_en_q[b] <= 1'b0;
          bank_we_q[b] <= 1'b0;
          bank_addr_q[b] <= '0;
          bank_wdata_q[b] <= 32'h00000000;
        end else begin
          bank_en_q[b] <= sel_v; // [R11]
          bank_we_q[b] <= sel_v && mst_we[sel_m]; // [R21]
          if (sel_v) begin
            bank_addr_q[b] <= loc[sel_m].word;
            bank_wdata_q[b] <= mst_wdata[sel_m];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Answers to masters
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mst_ack_q <= 3'h0;
      mst_err_q <= 3'h0;
    end else begin
      mst_ack_q <= granted | err_hit;
      mst_err_q <= err_hit; // [R21]
    end
  end

  // Banks answer one cycle after the command, so the read data lands two after the ack
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd1_q <= 3'h0;
      rd2_q <= 3'h0;
      bank1_q <= '0;
      bank2_q <= '0;
    end else begin
      rd1_q <= granted & ~mst_we;
      rd2_q <= rd1_q;
      for (int m = 0; m < N_MST; m++) begin
        bank1_q[m] <= loc[m].bank;
      end
      bank2_q <= bank1_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mst_rvalid_q <= 3'h0;
      mst_rdata_q <= '0;
    end else begin
      mst_rvalid_q <= rd2_q;
      for (int m = 0; m < N_MST; m++) begin
        if (rd2_q[m]) begin
          mst_rdata_q[m] <= bank_rdata[bank2_q[m]];
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_cpu_read_taken;
    mst_req[M_CPU] && !mst_we[M_CPU] && granted[M_CPU];
  endsequence

  sequence s_read_return;
    mst_ack_q[M_CPU] ##2 mst_rvalid_q[M_CPU];
  endsequence

  AST_ERR_NO_WRITE: assert property ( // [R21]
    err_hit[M_LINK] && mst_we[M_LINK] |=> !(|bank_we_q) || $past(|granted))
    else $error("reserved access touched memory");
  AST_CPU_READ_PIPE: assert property ( // [R11]
    s_cpu_read_taken |=> s_read_return)
    else $error("cpu read data late");
  AST_ROM_DECODE: assert property ( // [R02]
    cpu_addr >= ROM_LO && cpu_addr <= ROM_HI |=> cpu_region_q == REG_ROM)
    else $error("rom window misdecoded");
  AST_REMAP_RAM: assert property ( // [R01]
    cpu_addr <= BOOT_HI && boot_region_remap_select == REMAP_RAM
      |=> cpu_region_q == REG_RAM && cpu_slave_addr_q == RAM_LO + $past(cpu_addr))
    else $error("boot window not remapped to ram");
  AST_PATCH_DECODE: assert property ( // [R07]
    cpu_addr >= PATCH_LO && cpu_addr <= PATCH_HI |=> cpu_region_q == REG_PATCH)
    else $error("patch window misdecoded");
  AST_UNPOWERED_QUIET: assert property ( // [R15]
    !bank_pwr_en_q[3] |=> !bank_en_q[3])
    else $error("unpowered bank accessed");
  AST_RETAIN_KEPT: assert property ( // [R14]
    $stable(ram_retain_cfg) [*2] |-> bank_retain_q == ram_retain_cfg)
    else $error("retention setting lost");
  AST_PARALLEL: assert property ( // [R11]
    ram_req[M_LINK] && ram_req[M_CPU] && loc[M_LINK].bank[1] != loc[M_CPU].bank[1]
      && !otp_mirror_active |-> granted[M_LINK] && granted[M_CPU])
    else $error("masters on different arbiters not served together");
endmodule : smra_system_map

// file: smra_ram_model.sv
`timescale 1ns/1ns
// ****************
// Four sync RAM banks
// ****************
module smra_ram_model (
  input wire logic clk_sys,
  input wire logic [3:0] bank_en,
  input wire logic [3:0] bank_we,
  input wire logic [3:0][smra_pkg::WORD_W-1:0] bank_addr,
  input wire logic [3:0][31:0] bank_wdata,
  output logic [3:0][31:0] bank_rdata
);
  import smra_pkg::*;
  logic [31:0] mem_q [N_BANK][2**WORD_W];
  initial begin
    bank_rdata = '0;
  end
  // Idle read port toggles so stale data never passes for a fresh read
  always @(posedge clk_sys) begin
    for (int b = 0; b < N_BANK; b++) begin
      if (bank_en[b] && bank_we[b]) begin
        mem_q[b][bank_addr[b]] <= bank_wdata[b];
      end
      if (bank_en[b] && !bank_we[b]) begin
        bank_rdata[b] <= mem_q[b][bank_addr[b]];
      end else begin
        bank_rdata[b] <= ~bank_rdata[b];
      end
    end
  end
endmodule : smra_ram_model

// file: tb_system_map_and_ram_arbiter.sv
`timescale 1ns/1ns
module tb_system_map_and_ram_arbiter;
  import smra_pkg::*;
  logic clk_sys, arst_n, otp_mirror_active;
  logic [1:0] remap;
  logic [3:0] used, retain, bank_en_q, bank_we_q, bank_pwr_en_q, bank_retain_q;
  logic [2:0] mst_req, mst_we, mst_ack_q, mst_err_q, mst_rvalid_q;
  logic [2:0][31:0] mst_addr, mst_wdata, mst_rdata_q;
  logic [3:0][WORD_W-1:0] bank_addr_q;
  logic [3:0][31:0] bank_wdata_q, bank_rdata;
  logic [31:0] cpu_slave_addr_q;
  logic [7:0] cpu_slot_q;
  smra_region_type cpu_region_q;
  int err_total, checks;
  localparam logic [31:0] DEC_A [24] = '{32'h07f00000, 32'h07f1ffff, 32'h07f20000,
    32'h07f400ff, 32'h07f40100, 32'h07f80000, 32'h07f90000, 32'h07fd7fff, 32'h07fd8000,
    32'h400803ff, 32'h40080400, 32'h50000200, 32'h50000300, 32'h500016ff, 32'h50001700,
    32'h50003600, 32'h50003700, 32'h00020000, 32'h40000000, 32'h50002000, 32'he0000000,
    32'h50000000, 32'h50001000, 32'h50003000};
  localparam smra_region_type DEC_R [24] = '{REG_ROM, REG_ROM, REG_NONE, REG_OTP_CTRL,
    REG_NONE, REG_OTP_CELL, REG_NONE, REG_RAM, REG_NONE, REG_PATCH, REG_NONE, REG_APB,
    REG_NONE, REG_APB, REG_NONE, REG_APB, REG_NONE, REG_NONE, REG_LINK_CTRL, REG_RADIO,
    REG_PRIVATE, REG_APB, REG_APB, REG_APB};
  localparam smra_region_type REMAP_R [4] = '{REG_ROM, REG_OTP_CELL, REG_RAM, REG_NONE};

  smra_system_map DUT (.clk_sys(clk_sys), .arst_n(arst_n), .boot_region_remap_select(remap),
    .ram_banks_used(used), .ram_retain_cfg(retain), .otp_mirror_active(otp_mirror_active),
    .mst_req(mst_req), .mst_we(mst_we), .mst_addr(mst_addr), .mst_wdata(mst_wdata),
    .mst_ack_q(mst_ack_q), .mst_err_q(mst_err_q), .mst_rvalid_q(mst_rvalid_q),
    .mst_rdata_q(mst_rdata_q), .cpu_region_q(cpu_region_q),
    .cpu_slave_addr_q(cpu_slave_addr_q), .cpu_slot_q(cpu_slot_q), .bank_en_q(bank_en_q),
    .bank_we_q(bank_we_q), .bank_addr_q(bank_addr_q), .bank_wdata_q(bank_wdata_q),
    .bank_rdata(bank_rdata), .bank_pwr_en_q(bank_pwr_en_q), .bank_retain_q(bank_retain_q));
  smra_ram_model ram (.clk_sys(clk_sys), .bank_en(bank_en_q), .bank_we(bank_we_q),
    .bank_addr(bank_addr_q), .bank_wdata(bank_wdata_q), .bank_rdata(bank_rdata));

  // ****************
  // Checking and closing
  // ****************
  task automatic cmp_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_vec

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // One uncontended access; e marks an expected refusal, x the read data
  task automatic acc(input int m, input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic e, input int bk, input logic [31:0] x);
    int n;
    logic [3:0] en_seen;
    n = 0;
    @(posedge clk_sys);
    mst_req[m] <= 1'b1; // At most one access per three cycles
    mst_we[m] <= w;
    mst_addr[m] <= a;
    mst_wdata[m] <= d;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (mst_ack_q[m] !== 1'b1 && n < 20);
    cmp_vec("ack_latency", 32'h1, 32'(n));
    cmp_vec("err", 32'(e), 32'(mst_err_q[m]));
    en_seen = bank_en_q;
    if (!e) begin
      cmp_vec("bank_en", 32'h1, 32'(en_seen[bk]));
      cmp_vec("bank_word", 32'((a - BANK_LO[bk]) >> 2), 32'(bank_addr_q[bk]));
    end else begin
      cmp_vec("bank_en_refused", 32'h0, 32'(en_seen));
    end
    @(posedge clk_sys);
    mst_req[m] <= 1'b0;
    if (!e && !w) begin
      @(posedge clk_sys);
      #1;
      cmp_vec("rvalid", 32'h1, 32'(mst_rvalid_q[m]));
      cmp_vec("rdata", x, mst_rdata_q[m]);
    end
  endtask : acc

  // ****************
  // Scenarios
  // ****************
  task automatic t_decode;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      mst_addr[2] <= DEC_A[i];
      @(posedge clk_sys);
      #1;
      cmp_vec("region", 32'(DEC_R[i]), 32'(cpu_region_q));
      cmp_vec("slot", 32'(DEC_A[i][15:8]), 32'(cpu_slot_q));
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      remap <= 2'(s);
      mst_addr[2] <= 32'h00000100;
      @(posedge clk_sys);
      #1;
      cmp_vec("remap_region", 32'(REMAP_R[s]), 32'(cpu_region_q));
      if (s == 2) cmp_vec("remap_addr", RAM_LO + 32'h100, cpu_slave_addr_q);
    end
    @(posedge clk_sys);
    remap <= REMAP_ROM;
    $display("done decode");
  endtask : t_decode

  task automatic t_banks;
    logic [31:0] a;
    for (int b = 0; b < N_BANK; b++) begin
      for (int k = 0; k < 2; k++) begin
        a = (k == 0) ? BANK_LO[b] : BANK_HI[b] - 32'h3;
        acc(2, 1'b1, a, {16'hc0de, 8'(b), 8'(k)}, 1'b0, b, '0);
        acc(2, 1'b0, a, '0, 1'b0, b, {16'hc0de, 8'(b), 8'(k)});
      end
    end
    $display("done banks");
  endtask : t_banks

  task automatic t_parallel;
    @(posedge clk_sys);
    mst_we[2:1] <= 2'b00;
    mst_addr[1] <= BANK_LO[0];
    mst_addr[2] <= BANK_LO[2];
    mst_req[2:1] <= 2'b11;
    @(posedge clk_sys);
    #1;
    cmp_vec("par_ack", 32'h6, 32'(mst_ack_q));
    cmp_vec("par_en", 32'h5, 32'(bank_en_q));
    @(posedge clk_sys);
    mst_req[2:1] <= 2'b00;
    repeat (3) @(posedge clk_sys);
    $display("done parallel");
  endtask : t_parallel

  task automatic t_contend;
    int nl, nc, run, maxrun, both;
    nl = 0;
    nc = 0;
    run = 0;
    maxrun = 0;
    both = 0;
    @(posedge clk_sys);
    mst_addr[1] <= BANK_LO[0];
    mst_addr[2] <= BANK_LO[1];
    mst_req[2:1] <= 2'b11;
    @(posedge clk_sys);
    #1;
    cmp_vec("first_grant", 32'h2, 32'(mst_ack_q));
    repeat (24) begin
      @(posedge clk_sys);
      #1;
      if (mst_ack_q[1] === 1'b1) begin
        nl++;
        run++;
      end
      if (mst_ack_q[2] === 1'b1) begin
        nc++;
        run = 0;
      end
      if (mst_ack_q[2:1] === 2'b11) both++;
      if (run > maxrun) maxrun = run;
    end
    @(posedge clk_sys);
    mst_req[2:1] <= 2'b00;
    cmp_vec("link_run_max", 32'h2, (maxrun > 2) ? 32'(maxrun) : 32'h2);
    cmp_vec("cpu_served", 32'h1, 32'(nc > 0));
    cmp_vec("link_ahead", 32'h1, 32'(nl >= nc));
    cmp_vec("same_arb_dual", 32'h0, 32'(both));
    repeat (4) @(posedge clk_sys);
    $display("done contend");
  endtask : t_contend

  task automatic t_mirror;
    int n;
    n = 0;
    @(posedge clk_sys);
    otp_mirror_active <= 1'b1;
    mst_we[1:0] <= 2'b01;
    mst_addr[0] <= BANK_LO[1] + 32'h8;
    mst_addr[1] <= BANK_LO[1];
    mst_wdata[0] <= 32'h0f0f5a5a;
    mst_req[1:0] <= 2'b11;
    @(posedge clk_sys);
    #1;
    cmp_vec("mirror_grant", 32'h1, 32'(mst_ack_q));
    @(posedge clk_sys);
    mst_req[0] <= 1'b0;
    otp_mirror_active <= 1'b0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (mst_ack_q[1] !== 1'b1 && n < 6);
    cmp_vec("link_after", 32'h1, 32'(mst_ack_q[1]));
    @(posedge clk_sys);
    mst_req[1] <= 1'b0;
    acc(2, 1'b0, BANK_LO[1] + 32'h8, '0, 1'b0, 1, 32'h0f0f5a5a);
    $display("done mirror");
  endtask : t_mirror

  task automatic t_reserved;
    acc(2, 1'b1, 32'h07fd8000, 32'h1, 1'b1, 0, '0);
    acc(1, 1'b1, ROM_LO, 32'h5a5a0f0f, 1'b1, 0, '0);
    @(posedge clk_sys);
    used <= 4'h7;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_vec("pwr_en", 32'h7, 32'(bank_pwr_en_q));
    acc(2, 1'b1, BANK_LO[3], 32'hdead0000, 1'b1, 3, '0);
    @(posedge clk_sys);
    used <= 4'h3;
    retain <= 4'h4;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_vec("pwr_ret", 32'h7, 32'(bank_pwr_en_q));
    cmp_vec("retain", 32'h4, 32'(bank_retain_q));
    @(posedge clk_sys);
    used <= 4'hf;
    retain <= 4'h0;
    repeat (2) @(posedge clk_sys);
    acc(2, 1'b0, BANK_LO[3], '0, 1'b0, 3, 32'hc0de0300);
    repeat (4) @(posedge clk_sys);
    #1;
    cmp_vec("idle_ack", 32'h0, 32'(mst_ack_q));
    cmp_vec("idle_en", 32'h0, 32'(bank_en_q));
    $display("done reserved");
  endtask : t_reserved

  // ****************
  // Clock, reset, sequence
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #(4000 * 50);
    err_total++;
    tally_and_finish();
  end

  initial begin
    err_total = 0;
    checks = 0;
    arst_n = 1'b0;
    remap = REMAP_ROM;
    used = 4'hf;
    retain = 4'h0;
    otp_mirror_active = 1'b0;
    mst_req = '0;
    mst_we = '0;
    mst_addr = '0;
    mst_wdata = '0;
    repeat (10) @(posedge clk_sys);
    #1;
    cmp_vec("rst_pwr", 32'hf, 32'(bank_pwr_en_q));
    cmp_vec("rst_region", 32'(REG_NONE), 32'(cpu_region_q));
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_decode();
    t_banks();
    t_parallel();
    t_contend();
    t_mirror();
    t_reserved();
    tally_and_finish();
  end
endmodule : tb_system_map_and_ram_arbiter
